// *** hw/uotg_pkg.sv ***
package uotg_pkg;

	// Positions of the bits of the control word.
	localparam int CTL_MODULE_ENABLE = 0;
	localparam int CTL_OTG_OVERRIDE = 2;
	localparam int CTL_HOST_ENABLE = 3;
	localparam int CTL_DMINUS_PULLDOWN = 4;
	localparam int CTL_DPLUS_PULLDOWN = 5;
	localparam int CTL_DPLUS_PULLUP = 7;
	localparam int CTL_WIDTH = 8;

	localparam int EP_COUNT = 16;
	localparam int EP_PAIRS = 32;
	localparam int EP_NUM_W = 4;
	localparam int QUEUE_DEPTH = 16;
	localparam int QUEUE_CNT_W = 5;
	localparam logic [QUEUE_CNT_W-1:0] QUEUE_FULL = 5'h10;
	localparam logic [QUEUE_CNT_W-1:0] QUEUE_ONE = 5'h01;
	localparam logic [QUEUE_CNT_W-1:0] QUEUE_EMPTY = 5'h00;

	localparam int FULL_SPEED_KBPS = 12000;
	localparam int LOW_SPEED_KBPS = 1500;

	typedef enum logic [1:0] {
		UOTG_PID_OUT,
		UOTG_PID_IN,
		UOTG_PID_SETUP,
		UOTG_PID_OTHER
	} uotg_token_t;

	typedef enum logic {
		UOTG_SPEED_FULL,
		UOTG_SPEED_LOW
	} uotg_speed_t;

	typedef enum logic {
		UOTG_MODE_DEVICE,
		UOTG_MODE_HOST
	} uotg_mode_t;

	// Software control bits as one word.
	typedef struct packed {
		logic dplus_pullup_ctrl;
		logic unused_6;
		logic dplus_pulldown_ctrl;
		logic dminus_pulldown_ctrl;
		logic host_mode_enable;
		logic otg_manual_override;
		logic unused_1;
		logic module_enable_bit;
	} uotg_ctrl_t;

	// Line terminations driven onto the transceiver.
	typedef struct packed {
		logic dplus_pullup;
		logic dplus_pulldown;
		logic dminus_pulldown;
	} uotg_term_t;

	// A token classified for the shared data path.
	typedef struct packed {
		logic valid;
		logic rx;
		logic tx;
		logic [EP_NUM_W-1:0] endpoint;
		logic [EP_NUM_W:0] ep_pair;
	} uotg_dir_t;

	typedef struct packed {
		uotg_term_t term;
		logic vbus_meta;
		logic vbus_sync;
		uotg_dir_t dir;
		uotg_speed_t speed;
		logic speed_err;
		logic [QUEUE_CNT_W-1:0] queued;
	} uotg_state_t;

endpackage

// *** hw/uotg_line_term.sv ***
`timescale 1ns/1ps

// Summary of operation
// - In device mode without override the D+ pull-up is on only while module enable and module power are both set.
// - With override set the D+ pull-up follows the manual D+ pull-up bit.
// - VBUS below the session-valid level forces the D+ pull-up off whatever software asks.
// - Without override both pull-downs are on while host mode is enabled.
// - With override the D+ and D- pull-downs follow their own manual bits.
// - In device mode OUT and SETUP tokens are RX and IN tokens are TX.
// - In host mode OUT and SETUP tokens are TX and IN tokens are RX.
// - Full speed is allowed in both modes, low speed only as host.
// - Sixteen endpoints in two directions give 32 endpoint-direction pairs.
// - Up to 16 endpoint transfers can be queued at once.
// - One data path classifies and carries transfers for both modes.
// - Mode may change at run time without a reset of the block.
// - Suspend does not release the selected pull-up.
module uotg_line_term
	import uotg_pkg::*;
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic reset_in,
	// Software control.
	input wire uotg_ctrl_t ctrl_in,
	input wire logic module_power_bit_in,
	input wire logic low_speed_req_in,
	input wire logic bus_suspend_in,
	// Comparator level from the analog side.
	input wire logic vbus_session_valid_level_in,
	// Token and transfer queue.
	input wire logic token_valid_in,
	input wire uotg_token_t token_pid_in,
	input wire logic [EP_NUM_W-1:0] token_ep_in,
	input wire logic xfer_queue_in,
	input wire logic xfer_done_in,
	// Terminations.
	output uotg_term_t term_out,
	// Status.
	output uotg_mode_t mode_out,
	output uotg_speed_t speed_out,
	output logic speed_err_out,
	output uotg_dir_t dir_out,
	output logic [QUEUE_CNT_W-1:0] queued_out,
	output logic queue_ready_out
);

	uotg_state_t state_ff;
	uotg_state_t nxt_state;

	function automatic logic [EP_NUM_W:0] ep_pair(
		input logic [EP_NUM_W-1:0] ep,
		input logic tx
	);
		ep_pair = {ep, tx};
	endfunction

	logic host;
	logic can_queue;
	logic do_queue;
	logic do_done;

	// Mode is read live, so software may swap it at any time.
	assign host = ctrl_in.host_mode_enable;
	assign can_queue = state_ff.queued != QUEUE_FULL;
	assign do_queue = xfer_queue_in && can_queue;
	assign do_done = xfer_done_in && (state_ff.queued != QUEUE_EMPTY);

	always_comb begin
		nxt_state = state_ff;
		nxt_state.vbus_meta = vbus_session_valid_level_in;
		nxt_state.vbus_sync = state_ff.vbus_meta;
		// Suspend is not an input of the pull-up terms at all.
		if (ctrl_in.otg_manual_override) begin
			nxt_state.term.dplus_pullup = ctrl_in.dplus_pullup_ctrl;
			nxt_state.term.dplus_pulldown =
				ctrl_in.dplus_pulldown_ctrl;
			nxt_state.term.dminus_pulldown =
				ctrl_in.dminus_pulldown_ctrl;
		end else begin
			nxt_state.term.dplus_pullup = !host &&
				ctrl_in.module_enable_bit &&
				module_power_bit_in;
			nxt_state.term.dplus_pulldown = host;
			nxt_state.term.dminus_pulldown = host;
		end
		// Recomputed every cycle, so it comes back with VBUS.
		if (!state_ff.vbus_sync) begin
			nxt_state.term.dplus_pullup = 1'b0;
		end
		if (low_speed_req_in && host) begin
			nxt_state.speed = UOTG_SPEED_LOW;
			nxt_state.speed_err = 1'b0;
		end else begin
			nxt_state.speed = UOTG_SPEED_FULL;
			nxt_state.speed_err = low_speed_req_in;
		end
		nxt_state.dir.valid = token_valid_in &&
			(token_pid_in != UOTG_PID_OTHER);
		nxt_state.dir.endpoint = token_ep_in;
		nxt_state.dir.rx = 1'b0;
		nxt_state.dir.tx = 1'b0;
		unique case (token_pid_in)
			UOTG_PID_OUT, UOTG_PID_SETUP: begin
				nxt_state.dir.rx = !host;
				nxt_state.dir.tx = host;
			end
			UOTG_PID_IN: begin
				nxt_state.dir.rx = host;
				nxt_state.dir.tx = !host;
			end
			UOTG_PID_OTHER: begin
				nxt_state.dir.valid = 1'b0;
			end
		endcase
		nxt_state.dir.ep_pair =
			ep_pair(token_ep_in, nxt_state.dir.tx);
		if (do_queue && !do_done) begin
			nxt_state.queued = state_ff.queued + QUEUE_ONE;
		end else if (do_done && !do_queue) begin
			nxt_state.queued = state_ff.queued - QUEUE_ONE;
		end
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign term_out = state_ff.term;
	assign mode_out = host ? UOTG_MODE_HOST : UOTG_MODE_DEVICE;
	assign speed_out = state_ff.speed;
	assign speed_err_out = state_ff.speed_err;
	assign dir_out = state_ff.dir;
	assign queued_out = state_ff.queued;
	assign queue_ready_out = can_queue;

endmodule

// *** sim/uotg_cable.sv ***
`timescale 1ns/1ps
module uotg_cable (
	input logic clk_in,
	input logic drop_in,
	output logic vbus_out
);
	// The host powers the cable one cycle after it is asked to.
	initial vbus_out = 1'h0;
	always @(posedge clk_in) vbus_out <= !drop_in;
endmodule

// *** sim/uotg_line_term_chk.sv ***
`timescale 1ns/1ps
module uotg_line_term_chk
	import uotg_pkg::*;
(
	input logic clk_in, reset_in, module_power_bit_in, low_speed_req_in,
	input logic bus_suspend_in, vbus_session_valid_level_in,
	input logic token_valid_in, xfer_queue_in, xfer_done_in,
	input logic speed_err_out, queue_ready_out,
	input uotg_ctrl_t ctrl_in,
	input uotg_token_t token_pid_in,
	input logic [EP_NUM_W-1:0] token_ep_in,
	input uotg_term_t term_out,
	input uotg_speed_t speed_out,
	input uotg_dir_t dir_out,
	input logic [QUEUE_CNT_W-1:0] queued_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire ov = ctrl_in.otg_manual_override;
	wire hs = ctrl_in.host_mode_enable;
	wire vb = vbus_session_valid_level_in;
	wire pu = term_out.dplus_pullup;
	wire dev_on = !hs && ctrl_in.module_enable_bit && module_power_bit_in;
	wire tok = token_valid_in && token_pid_in != UOTG_PID_OTHER;
	wire tin = token_pid_in == UOTG_PID_IN;
	property p_pu_dev; (!ov && vb)[*4] |=> pu == $past(dev_on); endproperty
	a_pu_dev: assert property (p_pu_dev) else $error("pull-up off");
	property p_pu_ovr;
		(ov && vb)[*4] |=> pu == $past(ctrl_in.dplus_pullup_ctrl);
	endproperty
	a_pu_ovr: assert property (p_pu_ovr) else $error("manual pull-up");
	property p_vb_off; (!vb)[*4] |=> !pu; endproperty
	a_vb_off: assert property (p_vb_off) else $error("pull-up kept");
	property p_pd_host;
		!ov |=> term_out.dplus_pulldown == $past(hs)
			&& term_out.dminus_pulldown == $past(hs);
	endproperty
	a_pd_host: assert property (p_pd_host) else $error("pull-downs");
	property p_pd_ovr;
		ov |=> term_out.dplus_pulldown == $past(ctrl_in.dplus_pulldown_ctrl)
			&& term_out.dminus_pulldown == $past(ctrl_in.dminus_pulldown_ctrl);
	endproperty
	a_pd_ovr: assert property (p_pd_ovr) else $error("manual pull-downs");
	property p_dir;
		tok |=> dir_out.valid && dir_out.tx == ($past(tin) ^ $past(hs))
			&& dir_out.rx == !dir_out.tx;
	endproperty
	a_dir: assert property (p_dir) else $error("token direction");
	property p_pair;
		tok |=> dir_out.ep_pair == {$past(token_ep_in), dir_out.tx};
	endproperty
	a_pair: assert property (p_pair) else $error("endpoint pair");
	property p_speed;
		low_speed_req_in && !hs |=> speed_out == UOTG_SPEED_FULL && speed_err_out;
	endproperty
	a_speed: assert property (p_speed) else $error("device speed");
	property p_full;
		queued_out == QUEUE_FULL && xfer_queue_in && !xfer_done_in
			|=> queued_out == QUEUE_FULL && !queue_ready_out;
	endproperty
	a_full: assert property (p_full) else $error("queue overrun");
	property p_susp;
		vb[*3] ##0 (bus_suspend_in && pu && $stable(ctrl_in)
			&& $stable(module_power_bit_in)) |=> pu;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend drop");
	c_full: cover property (queued_out == QUEUE_FULL && xfer_queue_in);
	c_drop: cover property ($fell(pu));
	c_rx: cover property (dir_out.valid && dir_out.rx);
endmodule
bind uotg_line_term uotg_line_term_chk u_chk(.*);

// *** sim/uotg_line_term_tb.sv ***
`timescale 1ns/1ps
module uotg_line_term_tb;
	import uotg_pkg::*;
	logic clk_in = '0, reset_in = '1, pwr = '0, ls = '0, tv = '0, q = '0;
	logic d = '0, susp = '0, drop = '1, qr, vb, spe;
	uotg_mode_t md;
	uotg_speed_t spd;
	uotg_ctrl_t ctl = '0;
	uotg_token_t pid = UOTG_PID_OUT;
	logic [3:0] ep = '0;
	logic [4:0] qd;
	uotg_term_t term;
	uotg_dir_t dir, exq[$];
	integer n_fail = 0, checks = 0, seed = 52547, i;
	always #4 clk_in = ~clk_in;
	uotg_cable cab(.clk_in, .drop_in(drop), .vbus_out(vb));
	uotg_line_term uut(.clk_in, .reset_in, .ctrl_in(ctl),
		.module_power_bit_in(pwr), .low_speed_req_in(ls),
		.bus_suspend_in(susp), .vbus_session_valid_level_in(vb),
		.token_valid_in(tv), .token_pid_in(pid), .token_ep_in(ep),
		.xfer_queue_in(q), .xfer_done_in(d), .term_out(term), .mode_out(md),
		.speed_out(spd), .speed_err_out(spe), .dir_out(dir), .queued_out(qd),
		.queue_ready_out(qr));
	task chk(input string n, input logic [11:0] s, e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge clk_in);
	endtask
	task tok(input uotg_token_t p);
		logic t;
		logic [3:0] e;
		t = (p == UOTG_PID_IN) ^ ctl.host_mode_enable;
		e = 4'($random(seed));
		if (p != UOTG_PID_OTHER)
			exq.push_back({1'h1, !t, t, e, e, t});
		wt(1);
		tv <= 1'h1;
		pid <= p;
		ep <= e;
	endtask
	task give_verdict;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Token results are looked at mid-cycle, once they have settled.
	always @(negedge clk_in)
		if (dir.valid !== 1'h0)
			chk("dir", dir, exq.size() > 0 ? exq.pop_front() : '0);
	initial begin
		#20000;
		n_fail++;
		give_verdict;
	end
	initial begin
		wt(3);
		reset_in <= 1'h0;
		drop <= 1'h0;
		wt(6);
		ctl <= 8'h01;
		pwr <= 1'h1;
		wt(2);
		chk("pullup", term, 3'h4);
		pwr <= 1'h0;
		wt(2);
		chk("pullup", term, 3'h0);
		pwr <= 1'h1;
		susp <= 1'h1;
		wt(6);
		chk("suspend", term, 3'h4);
		drop <= 1'h1;
		wt(6);
		chk("vbus low", term, 3'h0);
		drop <= 1'h0;
		wt(6);
		chk("vbus back", term, 3'h4);
		for (i = 0; i < 8; i++) begin
			ctl <= {i[2], 1'h0, i[1], i[0], 4'h4};
			wt(2);
			chk("override", term, i[2:0]);
		end
		ctl <= 8'h09;
		wt(2);
		chk("host", term, 3'h3);
		chk("host speed", {md, spd, spe}, 3'h4);
		for (i = 0; i < 8; i++) begin
			if (i == 4) ctl <= 8'h01;
			if (i == 4) ls <= 1'h1;
			if (i == 4) wt(1);
			tok(uotg_token_t'(i[1:0]));
		end
		wt(1);
		tv <= 1'h0;
		chk("device speed", {md, spd, spe}, 3'h1);
		q <= 1'h1;
		wt(17);
		q <= 1'h0;
		wt(1);
		chk("queue", {qr, qd}, 6'h10);
		d <= 1'h1;
		wt(17);
		d <= 1'h0;
		wt(1);
		chk("queue", {qr, qd}, 6'h20);
		give_verdict;
	end
endmodule
